// file: verilog/fdb_pkg.sv
// constants for the receive demodulator back end
// assumes the demodulator clock is the core clock at 25 MHz
package fdb_pkg;
  // ----------------------------------------------------------------
  // clocking and frequency scaling
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 25_000_000;
  localparam longint IF_NOM_HZ = 200_000;
  localparam longint RANGE_WIDE_HZ = 100_000;
  localparam longint RANGE_NARROW_HZ = 50_000;
  localparam longint FREQ_SCALE = 32768;
  localparam logic signed [15:0] IF_NOM_CODE = 16'(IF_NOM_HZ * FREQ_SCALE / CLK_HZ);
  localparam logic signed [15:0] RANGE_WIDE = 16'(RANGE_WIDE_HZ * FREQ_SCALE / CLK_HZ);
  localparam logic signed [15:0] RANGE_NARROW = 16'(RANGE_NARROW_HZ * FREQ_SCALE / CLK_HZ);
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_CORR = 8'h04;
  localparam logic [7:0] ADDR_SYNC = 8'h08;
  localparam logic [7:0] ADDR_LOOP = 8'h0C;
  localparam logic [7:0] ADDR_CDR = 8'h10;
  localparam logic [7:0] ADDR_READBACK = 8'h14;
  localparam logic [7:0] ADDR_NADJ = 8'h18;
  // ----------------------------------------------------------------
  // field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] DSEL_LINEAR = 2'h0;
  localparam logic [1:0] DSEL_CORR = 2'h1;
  localparam logic [1:0] DSEL_ASK = 2'h2;
  localparam logic [2:0] MODE_SYNC_A = 3'h2;
  localparam logic [2:0] MODE_SYNC_B = 3'h3;
  localparam logic [9:0] PBW_RESET = 10'h009;
  localparam logic [9:0] DBW_RESET = 10'h03F;
  localparam logic [31:0] CDR_INC_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OVERSAMPLE = 32;
  localparam logic [4:0] PH_MID = 5'h10;
  localparam logic [3:0] MATCH_HOLD = 4'h9;
  localparam int ENV_SHIFT = 10;
  localparam int LOOP_SHIFT = 16;
  localparam int FILT_SHIFT = 10;
  localparam logic [7:0] LOOP_DIV = 8'hFF;
  localparam logic [4:0] SYNC_MIN = 5'h0C;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_HOLD = 2'b10} fdb_mst_t;
endpackage : fdb_pkg

// file: verilog/fdb_demod.sv
// receive demodulator back end: demod mux, post filter, slicer, clock
// recovery, frequency readback and correction loop, sync word matcher
// assumes synchronous samples from the limiter and signal strength paths
//
// What this block does
// - recovery runs off an oversample tick at 32 times the data rate
// - phase nudging tracks bit rates within two percent of the programmed rate
// - select code 01 chooses the correlator demodulator
// - post filter cutoff follows the ten-bit bandwidth setting in all modes
// - select code 00 chooses the linear discriminator
// - linear mode averages, slices and feeds recovery
// - select code 10 chooses amplitude demodulation
// - amplitude mode filters and envelope detects signal strength
// - frequency correction in all select codes but amplitude (10), from envelope of discriminator
// - signed 16-bit readback equals IF frequency scaled by 2^15 over clock
// - loop enable bit runs an integral-only loop adjusting the N divider
// - correction limited to 100 kHz wide or 50 kHz narrow filter
// - matcher compares sync word to bits and raises the match pin
// - match pin drops after nine recovered clock cycles
// - matching enabled for demod mode 010 or 011
// - length field selects 12, 16, 20 or 24 bits
// - tolerance field allows zero to three mismatched bits
// - correlator output sliced against zero
// - post filter is a second-order low pass
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module fdb_demod import fdb_pkg::*; #(
  parameter int FW = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // digitized IF path
  input wire logic signed [FW-1:0] lim_freq,
  input wire logic [6:0] rssi_code,
  input wire logic if_bw_wide,
  // host and synthesizer side
  output logic rx_data,
  output logic rx_clk,
  output logic match_lock,
  output logic signed [15:0] n_adjust
);
  // envelopes carry ENV_SHIFT fraction bits; a plain shifted step would stall
  // up to 2^ENV_SHIFT codes short of the input and bias the readback
  localparam int EW = 16 + ENV_SHIFT;
  typedef struct packed {
    logic [1:0] sel;
    logic [9:0] pbw;
    logic [2:0] dmode;
    logic [9:0] dbw;
    logic dotp;
    logic inv;
    logic [1:0] slen;
    logic [1:0] stol;
    logic [23:0] sword;
    logic [15:0] coef;
    logic loop_en;
    logic [31:0] cdr_inc;
    logic [31:0] rdata;
    logic signed [EW-1:0] fenv;
    logic signed [EW-1:0] aenv;
    logic signed [23:0] lp1;
    logic signed [23:0] lp2;
    logic sliced;
    logic [31:0] nco;
    logic [4:0] ph;
    logic prev_bit;
    logic bit_stb;
    logic rx_clk;
    logic rx_data;
    logic [23:0] shreg;
    fdb_mst_t mst;
    logic [3:0] hold;
    logic match;
    logic [4:0] errs;
    logic signed [31:0] integ;
    logic signed [15:0] nadj;
    logic [7:0] ldiv;
  } fdb_state_t;

  localparam fdb_state_t ST_RESET = '{sel: DSEL_CORR, pbw: PBW_RESET, dbw: DBW_RESET,
    cdr_inc: CDR_INC_RESET, mst: ST_IDLE, default: '0};

  fdb_state_t st;
  fdb_state_t st_next;

  // integer part of the envelope accumulators
  logic signed [15:0] fenv_q;
  logic signed [15:0] aenv_q;
  assign fenv_q = st.fenv[EW-1:ENV_SHIFT];
  assign aenv_q = st.aenv[EW-1:ENV_SHIFT];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic signed [16:0] fd;
  logic signed [16:0] ad;
  logic signed [16:0] cd;
  logic signed [23:0] x;
  logic signed [24:0] d1;
  logic signed [24:0] d2;
  logic signed [35:0] m1;
  logic signed [35:0] m2;
  logic [32:0] nco_sum;
  logic tick;
  logic [23:0] sh_n;
  logic [4:0] len;
  logic [4:0] errs;
  logic sync_en;
  logic signed [16:0] err;
  logic signed [31:0] lim_i;
  logic signed [31:0] integ_n;
  logic signed [15:0] rng;
  always_comb begin
    st_next = st;
    fd = 17'(lim_freq) - 17'(fenv_q);
    ad = 17'(signed'({9'h000, rssi_code})) - 17'(aenv_q);
    cd = 17'(lim_freq) - 17'(IF_NOM_CODE);
    x = '0;
    nco_sum = 33'(st.nco) + 33'(st.cdr_inc);
    tick = nco_sum[32];
    sh_n = {st.shreg[22:0], st.sliced};
    len = SYNC_MIN + 5'({st.slen, 2'b00}); // 00..11 give 12..24
    errs = '0;
    sync_en = (st.dmode == MODE_SYNC_A) || (st.dmode == MODE_SYNC_B);
    err = 17'(fenv_q) - 17'(IF_NOM_CODE);
    rng = if_bw_wide ? RANGE_WIDE : RANGE_NARROW;
    lim_i = 32'(rng) <<< LOOP_SHIFT;
    integ_n = st.integ;
    d1 = '0;
    d2 = '0;
    m1 = '0;
    m2 = '0;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SETUP: begin
          st_next.sel = reg_wdata[1:0];
          st_next.pbw = reg_wdata[11:2];
          st_next.dmode = reg_wdata[14:12];
        end
        ADDR_CORR: begin
          st_next.dbw = reg_wdata[9:0];
          st_next.dotp = reg_wdata[10];
          st_next.inv = reg_wdata[11];
        end
        ADDR_SYNC: begin
          st_next.slen = reg_wdata[1:0];
          st_next.stol = reg_wdata[3:2];
          st_next.sword = reg_wdata[31:8];
        end
        ADDR_LOOP: begin
          st_next.coef = reg_wdata[15:0];
          st_next.loop_en = reg_wdata[16];
        end
        ADDR_CDR: st_next.cdr_inc = reg_wdata;
        default: ;
      endcase
    end
    // read data stands in the cycle after the strobe only
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SETUP: st_next.rdata = {17'h00000, st.dmode, st.pbw, st.sel};
        ADDR_CORR: st_next.rdata = {20'h00000, st.inv, st.dotp, st.dbw};
        ADDR_SYNC: st_next.rdata = {st.sword, 4'h0, st.stol, st.slen};
        ADDR_LOOP: st_next.rdata = {15'h0000, st.loop_en, st.coef};
        ADDR_CDR: st_next.rdata = st.cdr_inc;
        ADDR_READBACK: st_next.rdata = {15'h0000, st.match, fenv_q};
        ADDR_NADJ: st_next.rdata = 32'(st.nadj);
        default: st_next.rdata = '0;
      endcase
    end
    // envelope of the discriminator; at zero error it settles at IF_NOM_CODE
    st_next.fenv = st.fenv + EW'(fd);
    st_next.aenv = st.aenv + EW'(ad);
    // demodulator input mux; each source is centred so one zero slicer serves all
    case (st.sel)
      DSEL_CORR: begin
        // band limited by the discriminator setting, then optional invert
        if (cd > 17'(signed'({7'h00, st.dbw}))) begin
          cd = 17'(signed'({7'h00, st.dbw}));
        end else if (cd < -17'(signed'({7'h00, st.dbw}))) begin
          cd = -17'(signed'({7'h00, st.dbw}));
        end
        x = st.inv ? -24'(cd <<< 6) : 24'(cd <<< 6);
      end
      DSEL_LINEAR: x = 24'(fd <<< 6); // frequency minus its average
      DSEL_ASK: x = 24'(ad <<< 6); // strength minus its envelope
      default: x = '0;
    endcase
    // two cascaded one-pole sections make the second-order post filter
    d1 = 25'(x) - 25'(st.lp1);
    m1 = 36'(d1) * 36'(signed'({1'b0, st.pbw}));
    st_next.lp1 = st.lp1 + 24'(m1 >>> FILT_SHIFT);
    d2 = 25'(st.lp1) - 25'(st.lp2);
    m2 = 36'(d2) * 36'(signed'({1'b0, st.pbw}));
    st_next.lp2 = st.lp2 + 24'(m2 >>> FILT_SHIFT);
    st_next.sliced = ~st.lp2[23]; // threshold at zero
    // oversample tick from the rate register, 32 ticks per bit
    st_next.nco = nco_sum[31:0];
    st_next.bit_stb = 1'b0;
    if (tick) begin
      st_next.ph = st.ph + 5'h01;
      st_next.prev_bit = st.sliced;
      if (st.sliced != st.prev_bit) begin
        // edge seen early in the bit: hold back; late: jump ahead
        if (st.ph != 5'h00 && st.ph < PH_MID) begin
          st_next.ph = st.ph;
        end else if (st.ph >= PH_MID) begin
          st_next.ph = st.ph + 5'h02;
        end
      end
      if (st_next.ph == PH_MID && st.ph != PH_MID) begin
        st_next.bit_stb = 1'b1;
        st_next.rx_data = st.sliced;
      end
      st_next.rx_clk = st_next.ph[4];
    end
    // sync word matcher over the newest len bits, MSB received first
    for (int i = 0; i < 24; i++) begin
      if (5'(i) < len && sh_n[i] != st.sword[i]) begin
        errs = errs + 5'h01;
      end
    end
    st_next.errs = errs;
    if (st.bit_stb) begin
      st_next.shreg = sh_n;
    end
    case (st.mst)
      ST_IDLE: begin
        if (st.bit_stb && sync_en && errs <= 5'(st.stol)) begin
          st_next.mst = ST_HOLD;
          st_next.hold = MATCH_HOLD;
          st_next.match = 1'b1;
        end
      end
      ST_HOLD: begin
        if (st.bit_stb) begin
          st_next.hold = st.hold - 4'h1; // counts recovered clocks
          if (st.hold == 4'h1) begin
            st_next.match = 1'b0;
            st_next.mst = ST_IDLE;
          end
        end
      end
      default: begin
        st_next.mst = ST_IDLE;
        st_next.match = 1'b0;
      end
    endcase
    // integral-only loop on a slow tick, held off with loop_en clear or for select code DSEL_ASK; windup clamped to range
    st_next.ldiv = st.ldiv + 8'h01;
    if (!st.loop_en || st.sel == DSEL_ASK) begin
      st_next.integ = '0;
      st_next.nadj = '0;
    end else if (st.ldiv == LOOP_DIV) begin
      integ_n = st.integ + 32'(34'(err) * 34'(signed'({1'b0, st.coef})));
      if (integ_n > lim_i) begin
        integ_n = lim_i;
      end else if (integ_n < -lim_i) begin
        integ_n = -lim_i;
      end
      st_next.integ = integ_n;
      st_next.nadj = -16'(integ_n >>> LOOP_SHIFT);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= ST_RESET;
    end else begin
      st <= st_next;
    end
  end

  assign reg_rdata = st.rdata;
  assign rx_data = st.rx_data;
  assign rx_clk = st.rx_clk;
  assign match_lock = st.match;
  assign n_adjust = st.nadj;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_corr_slice: assert property (@(posedge core_clk) disable iff (!nrst)
    1'b1 |=> st.sliced == ~$past(st.lp2[23], 1))
    else $error("slicer not at zero threshold");
  a_bit_phase: assert property (@(posedge core_clk) disable iff (!nrst)
    st.bit_stb |-> st.ph == PH_MID && st.rx_clk)
    else $error("bit sampled off mid phase");
  a_match_start: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(st.match) |-> st.hold == MATCH_HOLD && $past(st.bit_stb))
    else $error("match raised without a bit");
  a_match_len: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(st.match) |-> $past(st.hold) == 4'h1 && $past(st.bit_stb))
    else $error("match dropped early");
  a_sync_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(st.match) |-> $past(st.dmode) == MODE_SYNC_A || $past(st.dmode) == MODE_SYNC_B)
    else $error("match in wrong mode");
  a_tol_ok: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(st.match) |-> st.errs <= 5'($past(st.stol)))
    else $error("match beyond tolerance");
  a_range_clip: assert property (@(posedge core_clk) disable iff (!nrst)
    st.nadj <= RANGE_WIDE && st.nadj >= -RANGE_WIDE)
    else $error("correction out of range");
  a_loop_off: assert property (@(posedge core_clk) disable iff (!nrst)
    (!st.loop_en || st.sel == DSEL_ASK) |=> st.nadj == 16'sh0000)
    else $error("loop acting while off");
  a_rb_value: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_READBACK |=> st.rdata[15:0] == $past(fenv_q))
    else $error("readback mismatch");
endmodule : fdb_demod

// file: dv/fdb_tx_model.sv
// far-side transmitter model: limiter frequency and signal strength codes
// assumes the demodulator samples both codes on every rising core_clk edge
`timescale 1ns/10ps
module fdb_tx_model import fdb_pkg::*; (
  // clock
  input wire logic core_clk,
  // digitized IF path driven into the demodulator
  output logic signed [15:0] lim_freq,
  output logic [6:0] rssi_code
);
  localparam int DEV = 26; // about 20 kHz of deviation in frequency code units
  int bit_cyc = 64;
  int offset = 0;
  logic noise = 1'b0;
  logic cur = 1'b0;
  logic keyed = 1'b0;
  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  // one-code dither so an idle carrier never looks like a frozen line
  always_ff @(posedge core_clk) begin
    noise <= ~noise;
  end
  assign lim_freq = 16'(int'(IF_NOM_CODE) + offset + (keyed ? (cur ? DEV : -DEV) : 0)
    + int'(noise));
  // keyed and idle strength sit far apart, the spread a peak factor of six expects
  assign rssi_code = (keyed && cur) ? 7'h64 : (noise ? 7'h0A : 7'h0B);
  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  // a bit lasts bit_cyc clocks; caller enters just after a rising edge
  task automatic send_bit(input logic b);
    cur <= b;
    keyed <= 1'b1;
    repeat (bit_cyc) @(posedge core_clk);
  endtask : send_bit
  // alternating preamble, word most significant bit first, short tail
  task automatic send_frame(input logic [23:0] word, input int nbits);
    for (int i = 0; i < 32; i++) send_bit(~i[0]);
    for (int i = nbits - 1; i >= 0; i--) send_bit(word[i]);
    for (int i = 0; i < 8; i++) send_bit(i[0]);
    keyed <= 1'b0;
  endtask : send_frame
endmodule : fdb_tx_model

// file: dv/fdb_demod_tb.sv
// self-checking bench for the demodulator back end
// assumes fdb_demod and fdb_tx_model are compiled beside it
`timescale 1ns/10ps
module fdb_demod_tb import fdb_pkg::*; ();
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [15:0] lim_freq;
  logic [6:0] rssi_code;
  logic if_bw_wide = 1'b1;
  logic rx_data;
  logic rx_clk;
  logic match_lock;
  logic signed [15:0] n_adjust;
  logic rd_q = 1'b0;
  logic [63:0] notes[$];
  int mismatches = 0;
  int compares = 0;
  // sel, len, tol, errs, mode, bit period, match expected
  int tbl [7][7] = '{'{1, 0, 0, 0, 2, 64, 1}, '{1, 3, 1, 1, 3, 63, 1}, '{1, 1, 0, 1, 2, 65, 0},
    '{1, 2, 3, 3, 3, 64, 1}, '{1, 0, 0, 0, 0, 64, 0}, '{0, 1, 0, 0, 2, 64, 1},
    '{2, 0, 0, 0, 3, 64, 1}};
  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  fdb_demod DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lim_freq(lim_freq),
    .rssi_code(rssi_code), .if_bw_wide(if_bw_wide), .rx_data(rx_data), .rx_clk(rx_clk),
    .match_lock(match_lock), .n_adjust(n_adjust));
  fdb_tx_model tx (.core_clk(core_clk), .lim_freq(lim_freq), .rssi_code(rssi_code));
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // a gap cycle after each strobe keeps any signal from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({e, m});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // read data stand only in the cycle after the strobe; sample mid-cycle
  always @(negedge core_clk) begin
    logic [63:0] n;
    if (rd_q && notes.size() > 0) begin
      n = notes.pop_front();
      check(reg_rdata & n[31:0], n[63:32]);
    end
    rd_q = reg_rd;
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] w;
    logic hit;
    logic prev;
    int n;
    void'($urandom(32'h8879));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // reset values, writable fields and an unmapped place
    rd(ADDR_SETUP, (32'(PBW_RESET) << 2) | 32'(DSEL_CORR), 32'h7FFF);
    rd(ADDR_CORR, 32'(DBW_RESET), 32'h3FF);
    // model deviation near 20 kHz gives K = 10: bandwidth 313, K/2 odd so invert set
    wr(ADDR_CORR, 32'h0000_0939);
    rd(ADDR_CORR, 32'h0000_0939, 32'hFFF);
    w = $urandom;
    wr(ADDR_SYNC, w);
    rd(ADDR_SYNC, w & 32'hFFFFFF0F, 32'hFFFFFF0F);
    wr(ADDR_LOOP, w & 32'hFFFEFFFF);
    rd(ADDR_LOOP, w & 32'h0000FFFF, 32'h1FFFF);
    wr(8'h1C, w);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    wr(ADDR_CDR, 32'h80000000); // oversample tick every 2 clocks, 32 per 64-clock bit
    // sync frames over modes, lengths, tolerances and rate error
    foreach (tbl[i]) begin
      tx.bit_cyc = tbl[i][5];
      wr(ADDR_SETUP, {17'h0, 3'(tbl[i][4]), 10'h100, 2'(tbl[i][0])});
      w = $urandom;
      wr(ADDR_SYNC, {w[23:0], 4'h0, 2'(tbl[i][2]), 2'(tbl[i][1])});
      hit = 1'b0;
      fork
        // correlator rows run with the invert bit set, so the word goes out inverted
        tx.send_frame(w[23:0] ^ 24'((1 << tbl[i][3]) - 1) ^ {24{tbl[i][0] == 1}},
          12 + 4 * tbl[i][1]);
        begin
          for (int c = 0; c < 60 * tbl[i][5] && !hit; c++) begin
            @(negedge core_clk);
            hit = match_lock;
          end
          if (hit) begin
            // the last word bit is the one the match was made on
            check(32'(rx_data), 32'(w[0] ^ (tbl[i][3] != 0)));
            n = 0;
            prev = rx_clk;
            for (int c = 0; c < 20 * tbl[i][5] && match_lock; c++) begin
              @(negedge core_clk);
              n += int'(rx_clk && !prev);
              prev = rx_clk;
            end
            check(32'(n), 32'd9);
          end
        end
      join
      check(32'(hit), 32'(tbl[i][6]));
    end
    // frequency readback on a clean carrier in linear mode
    wr(ADDR_SETUP, {17'h0, 3'h0, 10'h100, DSEL_LINEAR});
    repeat (6000) @(posedge core_clk);
    rd(ADDR_READBACK, 32'(IF_NOM_CODE) & 32'hFFFE, 32'h1FFFE);
    // internal correction loop, then the range clamp on the narrow filter
    tx.offset <= 40;
    wr(ADDR_LOOP, {15'h0, 1'b1, 16'd839});
    repeat (12000) @(posedge core_clk);
    check(32'(n_adjust != 0 && (n_adjust < 0 ? -n_adjust : n_adjust) <= RANGE_WIDE), 1);
    tx.offset <= 300;
    if_bw_wide <= 1'b0;
    repeat (12000) @(posedge core_clk);
    check(32'((n_adjust < 0 ? -n_adjust : n_adjust) <= RANGE_NARROW), 32'd1);
    // a large steady error drives the correction to the full narrow limit
    rd(ADDR_NADJ, 32'(-RANGE_NARROW), 32'hFFFFFFFF);
    // no correction in amplitude mode, nor with the loop disabled
    wr(ADDR_SETUP, {17'h0, 3'h0, 10'h100, DSEL_ASK});
    repeat (300) @(posedge core_clk);
    check(32'(n_adjust), 32'h0);
    wr(ADDR_SETUP, {17'h0, 3'h0, 10'h100, DSEL_LINEAR});
    wr(ADDR_LOOP, {15'h0, 1'b0, 16'd839});
    repeat (300) @(posedge core_clk);
    check(32'(n_adjust), 32'h0);
    end_of_test();
  end
endmodule : fdb_demod_tb
